/* File: vlmc_pkg.sv */
package vlmc_pkg;

  // Lane configurations as selected by the straps
  typedef enum logic [2:0] {
    CFG_LINK_NORM = 3'h1,
    CFG_LINK_REV  = 3'h2,
    CFG_VID_NORM  = 3'h3,
    CFG_VID_REV   = 3'h4,
    CFG_CONC_NORM = 3'h5,
    CFG_CONC_REV  = 3'h6
  } vlmc_cfg_type;

  // Video port operating modes
  typedef enum logic [1:0] {
    MODE_STD        = 2'h0,
    MODE_DUAL_INDEP = 2'h1,
    MODE_DUAL_SIMUL = 2'h2
  } vlmc_mode_type;

  // Register byte addresses
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_INT_STAT  = 8'h08;
  localparam logic [7:0]  REG_INT_MASK  = 8'h0C;
  localparam logic [7:0]  REG_TVCLK_CNT = 8'h10;

  // Interrupt status / mask bit positions
  localparam int unsigned INT_W            = 4;
  localparam int unsigned INT_PORT_B       = 0;
  localparam int unsigned INT_PORT_C       = 1;
  localparam int unsigned INT_FIELD_STALL  = 2;
  localparam int unsigned INT_MODE_REFUSED = 3;

  // Lane geometry
  localparam int unsigned LANES          = 16;
  localparam int unsigned VIDEO_LANES    = 8;
  localparam int unsigned PORT_C_LANE    = 4;
  localparam logic [3:0]  MIRROR_TOP     = 4'hF;
  localparam logic [3:0]  LINK_LANE_NORM = 4'h0;
  localparam logic [3:0]  LINK_LANE_REV  = 4'hF;

  // Logical receive lanes of the video sideband inputs
  localparam int unsigned RX_TV_CLOCK     = 0;
  localparam int unsigned RX_PORT_B_INT   = 1;
  localparam int unsigned RX_FIELD_STALL  = 2;
  localparam int unsigned RX_PORT_C_INT   = 5;

  // Values after reset
  localparam vlmc_cfg_type  CFG_RST   = CFG_LINK_NORM;
  localparam vlmc_mode_type MODE_RST  = MODE_STD;
  localparam logic [3:0]    MASK_RST  = 4'h0;
  localparam logic [15:0]   TVCNT_RST = 16'h0000;

endpackage

/* File: vlmc_top.sv */
`timescale 1ns/100ps
// Functional notes
// R01: Three straps pick one of six configurations
// R02: Slot-reverse strap low selects reversed variant
// R03: Normal video: port B lanes 0-3, C 4-7
// R04: Reversed video, normal concurrent: lane k to 15-k
// R05: Reversed concurrent uses normal video lane map
// R06: Sideband inputs on rx lanes 0,1,2,5
// R07: Graphics-only variant never reverses lanes
// R08: Video mode reconfigurable at run time
// R09: Standard mode: three data pairs plus clock
// R10: Dual modes drive both ports, standard drives port B only
// R11: Dual independent: separate stream per port
// R12: Dual simultaneous: same pixels on both ports
// R13: Dual simultaneous leaves second pipeline free
// R14: Concurrent link is one lane, at lane 0, or at lane 15 in reversed concurrent
// R15: Mirroring is about the lane 7/8 boundary
// R16: Straps sampled at reset, held until next
// R17: Link-only gives all lanes to the link
// R18: Dual mode refused without video present
module vlmc_top (
  input  wire logic        i_mclk,                // Core clock, 200 MHz
  input  wire logic        i_srst,                // Synchronous reset, active high
  input  wire logic        i_slot_reverse_strap,  // Low selects reversed layout
  input  wire logic        i_video_present_strap, // High when video port fitted
  input  wire logic        i_concurrent_strap,    // High for video plus link
  input  wire logic        i_igd_only_strap,      // High on graphics-only variant
  input  wire logic [7:0]  i_addr,                // Register byte address
  input  wire logic [31:0] i_wdata,               // Register write data
  input  wire logic        i_wr,                  // Write strobe
  input  wire logic        i_rd,                  // Read strobe
  output logic      [31:0] o_rdata,               // Read data, cycle after read
  output logic             o_irq,                 // Level interrupt
  input  wire logic [3:0]  i_pipe0_sym,           // Pipe 0 symbol: red,green,blue,clock
  input  wire logic [3:0]  i_pipe1_sym,           // Pipe 1 symbol: red,green,blue,clock
  output logic             o_pipe1_free,          // Second pipeline unused by video
  input  wire logic [15:0] i_link_tx,             // Graphics link transmit lanes
  output logic      [15:0] o_link_rx,             // Graphics link receive lanes
  output logic      [15:0] o_lane_tx_positive,    // Lane transmit, true side
  output logic      [15:0] o_lane_tx_negative,    // Lane transmit, complement side
  output logic      [15:0] o_lane_tx_oe,          // Lane transmit driven
  input  wire logic [15:0] i_lane_rx_positive,    // Lane receive pins
  output logic             o_video_active         // Video owns lanes
);

  typedef struct packed {
    logic [3:0]            strap_s1;
    logic [3:0]            strap_s2;
    logic                  latched;
    logic                  igd;
    vlmc_pkg::vlmc_cfg_type  cfg;
    vlmc_pkg::vlmc_mode_type mode;
    logic [3:0]            mask;
    logic [3:0]            stat;
    logic [15:0]           tvcnt;
    logic [15:0]           rx_s1;
    logic [15:0]           rx_s2;
    logic [3:0]            rx_prev;
    logic                  armed;
    logic [15:0]           tx;
    logic [15:0]           tx_oe;
    logic [15:0]           link_rx;
    logic [31:0]           rdata;
  } vlmc_state_type;

  vlmc_state_type s_q;
  vlmc_state_type s_d;

  logic        mirror;
  logic        video_on;
  logic        link_only;
  logic [3:0]  link_lane;
  logic [3:0]  lk;
  logic [7:0]  vid_sym;
  logic [7:0]  vid_en;
  logic [15:0] rxv;
  logic [3:0]  side;
  logic [3:0]  ev;
  logic [3:0]  clr;
  logic        ctrl_wr;
  logic        dual_req;
  logic        refuse;
  logic [1:0]  req_mode;

  // Strap order: [0] slot reverse, [1] video present, [2] concurrent, [3] graphics only
  function automatic vlmc_pkg::vlmc_cfg_type decode_cfg(input logic [3:0] st);
    logic rev;
    rev = ~st[0] & ~st[3];                                                     // R02 R07
    if (!st[1]) begin
      decode_cfg = rev ? vlmc_pkg::CFG_LINK_REV : vlmc_pkg::CFG_LINK_NORM;    // R01
    end else if (st[2]) begin
      decode_cfg = rev ? vlmc_pkg::CFG_CONC_REV : vlmc_pkg::CFG_CONC_NORM;    // R01
    end else begin
      decode_cfg = rev ? vlmc_pkg::CFG_VID_REV : vlmc_pkg::CFG_VID_NORM;      // R01
    end
  endfunction

  always_comb begin
    s_d       = s_q;
    lk        = 4'h0;
    // Mirror about the 7/8 boundary: lane k pairs with lane 15-k
    mirror    = (s_q.cfg == vlmc_pkg::CFG_VID_REV) ||
                (s_q.cfg == vlmc_pkg::CFG_CONC_NORM);                         // R04 R05 R15
    video_on  = s_q.latched && (s_q.cfg >= vlmc_pkg::CFG_VID_NORM);
    link_only = s_q.latched && !video_on;
    link_lane = (s_q.cfg == vlmc_pkg::CFG_CONC_REV) ? vlmc_pkg::LINK_LANE_REV
                                                   : vlmc_pkg::LINK_LANE_NORM; // R14
    // Port B always from pipe 0; port C copies pipe 0 when simultaneous
    vid_sym[3:0] = i_pipe0_sym;                                                // R09
    vid_sym[7:4] = (s_q.mode == vlmc_pkg::MODE_DUAL_SIMUL) ? i_pipe0_sym
                                                           : i_pipe1_sym;      // R11 R12 R13
    vid_en[3:0]  = 4'hF;                                                       // R09
    vid_en[7:4]  = (s_q.mode == vlmc_pkg::MODE_STD) ? 4'h0 : 4'hF;             // R10
    rxv          = 16'h0000;
    s_d.link_rx  = 16'h0000;
    for (int p = 0; p < vlmc_pkg::LANES; p++) begin
      lk = mirror ? (vlmc_pkg::MIRROR_TOP - 4'(p)) : 4'(p);                   // R03 R04 R15
      rxv[lk] = s_q.rx_s2[p];                                                  // R06
      if (video_on && (32'(lk) < vlmc_pkg::VIDEO_LANES) && vid_en[lk[2:0]]) begin
        s_d.tx[p]    = vid_sym[lk[2:0]];                                       // R03 R05
        s_d.tx_oe[p] = 1'b1;
      end else if (link_only) begin
        s_d.tx[p]      = i_link_tx[p];                                         // R17
        s_d.tx_oe[p]   = 1'b1;
        s_d.link_rx[p] = s_q.rx_s2[p];                                         // R17
      end else if (video_on && (s_q.cfg >= vlmc_pkg::CFG_CONC_NORM) &&
                   (4'(p) == link_lane)) begin
        s_d.tx[p]      = i_link_tx[0];                                         // R14
        s_d.tx_oe[p]   = 1'b1;
        s_d.link_rx[0] = s_q.rx_s2[p];                                         // R14
      end else begin
        s_d.tx[p]    = 1'b0;
        s_d.tx_oe[p] = 1'b0;
      end
    end
    // Sideband inputs, only while the video port owns the lanes
    side = {rxv[vlmc_pkg::RX_PORT_C_INT], rxv[vlmc_pkg::RX_FIELD_STALL],
            rxv[vlmc_pkg::RX_PORT_B_INT], rxv[vlmc_pkg::RX_TV_CLOCK]};         // R06
    s_d.rx_prev = side;
    // Edge detectors skip the first video cycle; the earlier sample used the reset lane map
    s_d.armed   = video_on;
    ev = 4'h0;
    ev[vlmc_pkg::INT_PORT_B]      = video_on & s_q.armed & side[1] & ~s_q.rx_prev[1]; // R06
    ev[vlmc_pkg::INT_FIELD_STALL] = video_on & s_q.armed & side[2] & ~s_q.rx_prev[2]; // R06
    ev[vlmc_pkg::INT_PORT_C]      = video_on & s_q.armed & side[3] & ~s_q.rx_prev[3]; // R06
    if (video_on && s_q.armed && side[0] && !s_q.rx_prev[0]) begin
      s_d.tvcnt = s_q.tvcnt + 16'h0001;
    end
    // Mode writes; dual needs the video port, code 3 is not a mode
    ctrl_wr  = i_wr && (i_addr == vlmc_pkg::REG_CTRL);
    req_mode = i_wdata[1:0];
    dual_req = (req_mode == vlmc_pkg::MODE_DUAL_INDEP) ||
               (req_mode == vlmc_pkg::MODE_DUAL_SIMUL);
    refuse   = ctrl_wr && ((dual_req && !video_on) || (req_mode == 2'h3));     // R18
    if (ctrl_wr && !refuse) begin
      s_d.mode = vlmc_pkg::vlmc_mode_type'(req_mode);                          // R08
    end
    ev[vlmc_pkg::INT_MODE_REFUSED] = refuse;
    if (i_wr && (i_addr == vlmc_pkg::REG_INT_MASK)) begin
      s_d.mask = i_wdata[3:0];
    end
    // Write one to clear; a new event in the same cycle wins
    clr = (i_wr && (i_addr == vlmc_pkg::REG_INT_STAT)) ? i_wdata[3:0] : 4'h0;
    s_d.stat = (s_q.stat & ~clr) | ev;
    s_d.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        vlmc_pkg::REG_CTRL:      s_d.rdata = {30'h0, s_q.mode};
        vlmc_pkg::REG_STATUS:    s_d.rdata = {23'h0, s_q.igd, s_q.latched, video_on,
                                              s_q.mode, 1'b0, s_q.cfg};
        vlmc_pkg::REG_INT_STAT:  s_d.rdata = {28'h0, s_q.stat};
        vlmc_pkg::REG_INT_MASK:  s_d.rdata = {28'h0, s_q.mask};
        vlmc_pkg::REG_TVCLK_CNT: s_d.rdata = {16'h0, s_q.tvcnt};
        default:                 s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Straps taken once, first cycle after reset release
    if (!s_q.latched) begin
      s_d.cfg     = decode_cfg(s_q.strap_s2);                                  // R01 R16
      s_d.igd     = s_q.strap_s2[3];                                           // R07
      s_d.latched = 1'b1;                                                      // R16
      s_d.tx      = 16'h0000;
      s_d.tx_oe   = 16'h0000;
      s_d.link_rx = 16'h0000;
    end
    s_d.strap_s1 = {i_igd_only_strap, i_concurrent_strap,
                    i_video_present_strap, i_slot_reverse_strap};
    s_d.strap_s2 = s_q.strap_s1;
    s_d.rx_s1    = i_lane_rx_positive;
    s_d.rx_s2    = s_q.rx_s1;
    if (i_srst) begin
      s_d.latched = 1'b0;
      s_d.igd     = 1'b0;
      s_d.cfg     = vlmc_pkg::CFG_RST;
      s_d.mode    = vlmc_pkg::MODE_RST;
      s_d.mask    = vlmc_pkg::MASK_RST;
      s_d.stat    = 4'h0;
      s_d.tvcnt   = vlmc_pkg::TVCNT_RST;
      s_d.rx_prev = 4'h0;
      s_d.armed   = 1'b0;
      s_d.tx      = 16'h0000;
      s_d.tx_oe   = 16'h0000;
      s_d.link_rx = 16'h0000;
      s_d.rdata   = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_mclk) begin
    s_q <= s_d;
  end

  assign o_rdata            = s_q.rdata;
  assign o_irq              = |(s_q.stat & s_q.mask);
  assign o_pipe1_free       = (s_q.mode != vlmc_pkg::MODE_DUAL_INDEP);         // R13
  assign o_link_rx          = s_q.link_rx;
  assign o_lane_tx_positive = s_q.tx;
  assign o_lane_tx_negative = ~s_q.tx & s_q.tx_oe;
  assign o_lane_tx_oe       = s_q.tx_oe;
  assign o_video_active     = s_q.latched && (s_q.cfg >= vlmc_pkg::CFG_VID_NORM);

  property p_strap_decode;
    @(posedge i_mclk) disable iff (i_srst)
    !s_q.latched |=> s_q.cfg == decode_cfg($past(s_q.strap_s2));
  endproperty
  a_strap_decode: assert property (p_strap_decode) else $error("strap decode wrong"); // R01 R02

  property p_cfg_held;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.latched |=> $stable(s_q.cfg) && s_q.latched;
  endproperty
  a_cfg_held: assert property (p_cfg_held) else $error("configuration changed"); // R16

  property p_no_rev_igd;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.latched && s_q.igd |-> !(s_q.cfg inside {vlmc_pkg::CFG_LINK_REV,
      vlmc_pkg::CFG_VID_REV, vlmc_pkg::CFG_CONC_REV});
  endproperty
  a_no_rev_igd: assert property (p_no_rev_igd) else $error("reversed on graphics-only"); // R07

  property p_vid_norm;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.cfg == vlmc_pkg::CFG_VID_NORM && s_q.latched |=>
      s_q.tx[0] == $past(i_pipe0_sym[0]) && s_q.tx[3] == $past(i_pipe0_sym[3]) &&
      s_q.tx_oe[15:8] == 8'h00 && s_q.tx_oe[7] == ($past(s_q.mode) != vlmc_pkg::MODE_STD);
  endproperty
  a_vid_norm: assert property (p_vid_norm) else $error("normal video map wrong"); // R03 R10

  property p_mirror;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.cfg inside {vlmc_pkg::CFG_VID_REV, vlmc_pkg::CFG_CONC_NORM} && s_q.latched |=>
      s_q.tx[15] == $past(i_pipe0_sym[0]) && s_q.tx[12] == $past(i_pipe0_sym[3]) &&
      s_q.tx_oe[15:12] == 4'hF;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirrored map wrong"); // R04 R15

  property p_conc_rev;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.cfg == vlmc_pkg::CFG_CONC_REV && s_q.latched |=>
      s_q.tx[1] == $past(i_pipe0_sym[1]) && s_q.tx[15] == $past(i_link_tx[0]);
  endproperty
  a_conc_rev: assert property (p_conc_rev) else $error("reversed concurrent map wrong"); // R05 R14

  property p_conc_link;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.cfg == vlmc_pkg::CFG_CONC_NORM && s_q.latched |=>
      s_q.tx[0] == $past(i_link_tx[0]) && s_q.tx_oe[0] && s_q.link_rx[15:1] == 15'h0000;
  endproperty
  a_conc_link: assert property (p_conc_link) else $error("link not x1 on lane 0"); // R14

  property p_link_only;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.cfg <= vlmc_pkg::CFG_LINK_REV && s_q.latched |=>
      s_q.tx_oe == 16'hFFFF && s_q.tx == $past(i_link_tx);
  endproperty
  a_link_only: assert property (p_link_only) else $error("link-only lanes wrong"); // R17

  property p_dual_refused;
    @(posedge i_mclk) disable iff (i_srst)
    ctrl_wr && dual_req && !video_on |=>
      $stable(s_q.mode) && s_q.stat[vlmc_pkg::INT_MODE_REFUSED];
  endproperty
  a_dual_refused: assert property (p_dual_refused) else $error("dual mode not refused"); // R18

  property p_mode_write;
    @(posedge i_mclk) disable iff (i_srst)
    ctrl_wr && video_on && req_mode != 2'h3 |=> s_q.mode == $past(req_mode);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not reconfigured"); // R08

  property p_simul;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.mode == vlmc_pkg::MODE_DUAL_SIMUL && s_q.cfg == vlmc_pkg::CFG_VID_NORM &&
      !ctrl_wr |=> s_q.tx[7:4] == s_q.tx[3:0] && o_pipe1_free;
  endproperty
  a_simul: assert property (p_simul) else $error("ports differ in simultaneous"); // R12 R13

  property p_indep;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.mode == vlmc_pkg::MODE_DUAL_INDEP && s_q.cfg == vlmc_pkg::CFG_VID_NORM &&
      !ctrl_wr |=> s_q.tx[7:4] == $past(i_pipe1_sym) && !o_pipe1_free;
  endproperty
  a_indep: assert property (p_indep) else $error("port C not from second pipe"); // R11

  property p_port_b_irq;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.cfg == vlmc_pkg::CFG_VID_NORM && s_q.armed && s_q.rx_s2[1] &&
      !s_q.rx_prev[1] |=> s_q.stat[vlmc_pkg::INT_PORT_B];
  endproperty
  a_port_b_irq: assert property (p_port_b_irq) else $error("port B interrupt missed"); // R06

  property p_stat_sticky;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.stat[vlmc_pkg::INT_PORT_C] &&
      !(i_wr && i_addr == vlmc_pkg::REG_INT_STAT && i_wdata[vlmc_pkg::INT_PORT_C]) |=>
      s_q.stat[vlmc_pkg::INT_PORT_C];
  endproperty
  a_stat_sticky: assert property (p_stat_sticky) else $error("sticky status lost"); // R06

  property p_rdata_pulse;
    @(posedge i_mclk) disable iff (i_srst)
    !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_rdata_pulse: assert property (p_rdata_pulse) else $error("read data outstays"); // R08

  property p_link_rx_only;
    @(posedge i_mclk) disable iff (i_srst)
    s_q.latched && s_q.cfg <= vlmc_pkg::CFG_LINK_REV |=> o_link_rx == $past(s_q.rx_s2);
  endproperty
  a_link_rx_only: assert property (p_link_rx_only) else $error("link rx wrong"); // R17

  property p_unarmed_quiet;
    @(posedge i_mclk) disable iff (i_srst)
    !s_q.armed |=> s_q.stat[2:0] == ($past(s_q.stat[2:0]) & ~$past(clr[2:0])) &&
      $stable(s_q.tvcnt);
  endproperty
  a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("false sideband edge"); // R06

  c_conc_rev:  cover property (@(posedge i_mclk) disable iff (i_srst)
    s_q.latched && s_q.cfg == vlmc_pkg::CFG_CONC_REV);
  c_simul:     cover property (@(posedge i_mclk) disable iff (i_srst)
    video_on && s_q.mode == vlmc_pkg::MODE_DUAL_SIMUL);
  c_irq:       cover property (@(posedge i_mclk) disable iff (i_srst) o_irq);
  c_refused:   cover property (@(posedge i_mclk) disable iff (i_srst) refuse);

endmodule

/* File: vlmc_ext_dev.sv */
`timescale 1ns/100ps
module vlmc_ext_dev (
  input  wire logic        i_mirror,  // Board wired with lanes mirrored
  input  wire logic        i_tv_run,  // TV clock running
  input  wire logic [2:0]  i_evt,     // Port B int, port C int, field stall
  output logic      [15:0] o_lane_rx  // Physical receive lanes
);
  logic        tv_clk;
  logic        noise;
  logic [15:0] lg;

  // TV clock starts off phase with the core clock and stands still when idle
  initial begin
    tv_clk = 1'b0;
    #13;
    forever begin
      #80;
      tv_clk = i_tv_run ? ~tv_clk : 1'b0;
    end
  end

  initial begin
    noise = 1'b0;
    forever #7 noise = ~noise;
  end

  always_comb begin
    lg    = {16{noise}} ^ 16'hA5A5;  // Unused lanes never hold a steady level
    lg[0] = tv_clk;
    lg[1] = i_evt[0];
    lg[2] = i_evt[2];
    lg[5] = i_evt[1];
    for (int i = 0; i < 16; i++) begin
      o_lane_rx[i] = i_mirror ? lg[15 - i] : lg[i];
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
  logic        i_mclk;
  logic        i_srst;
  logic [3:0]  strap;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_irq;
  logic [3:0]  p0;
  logic [3:0]  p1;
  logic        o_pipe1_free;
  logic [15:0] lk;
  logic [15:0] o_link_rx;
  logic [15:0] tx_p;
  logic [15:0] tx_n;
  logic [15:0] tx_oe;
  logic [15:0] rx_tb;
  logic [15:0] rx_dev;
  logic [15:0] rx_pins;
  logic        o_video_active;
  logic        tv_run;
  logic [2:0]  evt;
  logic [15:0] lfsr;
  logic [31:0] rdv;
  logic [2:0]  cfg;
  logic [1:0]  mode;
  logic        tv_prev = 1'b0;
  int          tv_edges = 0;
  int          err_count;
  int          n_tests;

  // Link-only configs hand the receive pins to the bench, the rest to the device
  assign rx_pins = (cfg < 3'h3) ? rx_tb : rx_dev;

  vlmc_top dut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_slot_reverse_strap(strap[3]),
    .i_video_present_strap(strap[2]), .i_concurrent_strap(strap[1]),
    .i_igd_only_strap(strap[0]), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .i_pipe0_sym(p0), .i_pipe1_sym(p1),
    .o_pipe1_free(o_pipe1_free), .i_link_tx(lk), .o_link_rx(o_link_rx),
    .o_lane_tx_positive(tx_p), .o_lane_tx_negative(tx_n), .o_lane_tx_oe(tx_oe),
    .i_lane_rx_positive(rx_pins), .o_video_active(o_video_active)
  );

  vlmc_ext_dev dev (
    .i_mirror(cfg == 3'h4 || cfg == 3'h5), .i_tv_run(tv_run), .i_evt(evt),
    .o_lane_rx(rx_dev)
  );

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    tv_prev <= rx_pins[0];
    if (rx_pins[0] && !tv_prev) begin
      tv_edges <= tv_edges + 1;
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [2:0] exp_cfg(input logic [3:0] s);
    logic rv;
    rv = !s[3] && !s[0];
    if (!s[2]) return rv ? 3'h2 : 3'h1;
    if (!s[1]) return rv ? 3'h4 : 3'h3;
    return rv ? 3'h6 : 3'h5;
  endfunction

  // Expected {oe, tx} from the inputs of the previous cycle
  function automatic logic [31:0] exp_lane(input logic [2:0] c, input logic [1:0] m,
                                           input logic [3:0] a, input logic [3:0] b,
                                           input logic [15:0] k);
    logic [15:0] t;
    logic [15:0] e;
    logic [15:0] rt;
    logic [15:0] re;
    t = 16'h0000;
    e = 16'h0000;
    if (c < 3'h3) return {16'hFFFF, k};
    t[3:0] = a;
    e[3:0] = 4'hF;
    if (m != vlmc_pkg::MODE_STD) begin
      t[7:4] = (m == vlmc_pkg::MODE_DUAL_INDEP) ? b : a;
      e[7:4] = 4'hF;
    end
    for (int i = 0; i < 16; i++) begin
      rt[i] = (c == 3'h4 || c == 3'h5) ? t[15 - i] : t[i];
      re[i] = (c == 3'h4 || c == 3'h5) ? e[15 - i] : e[i];
    end
    if (c == 3'h5) begin
      rt[0] = k[0];
      re[0] = 1'b1;
    end
    if (c == 3'h6) begin
      rt[15] = k[0];
      re[15] = 1'b1;
    end
    return {re, rt};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    rdv = o_rdata;
  endtask

  task automatic lanes(input int n);
    logic [31:0] pv;
    logic [15:0] h[$];
    for (int j = 0; j < n; j++) begin
      @(posedge i_mclk);
      lfsr = lfsr_next(lfsr);
      p0    <= lfsr[3:0];
      p1    <= lfsr[7:4];
      lk    <= lfsr;
      rx_tb <= {lfsr[7:0], lfsr[15:8]};
      @(negedge i_mclk);
      if (j > 0) begin
        chk({tx_oe, tx_p & tx_oe}, pv);
        chk({16'h0, tx_n}, {16'h0, ~pv[15:0] & pv[31:16]});
      end
      pv = exp_lane(cfg, mode, p0, p1, lk);
      h.push_back(rx_tb);
      if (j >= 3 && cfg < 3'h3) chk({16'h0, o_link_rx}, {16'h0, h[j - 3]});
    end
  endtask

  task automatic start(input logic [3:0] s);
    @(posedge i_mclk);
    strap  <= s;
    i_srst <= 1'b1;
    repeat (12) @(posedge i_mclk);
    i_srst <= 1'b0;
    cfg  = exp_cfg(s);
    mode = vlmc_pkg::MODE_STD;
    repeat (3) @(posedge i_mclk);
    strap <= ~s;  // Straps move after reset; the latched layout must not
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (12000) @(posedge i_mclk);
    err_count++;
    stop_test;
  end

  initial begin
    int   e0;
    logic rf;
    {i_srst, strap, i_addr, i_wdata, i_wr, i_rd} = {1'b1, 4'hC, 8'h00, 32'h0, 2'b00};
    {p0, p1, lk, rx_tb, tv_run, evt} = {8'h00, 32'h0, 1'b0, 3'h0};
    {lfsr, cfg, mode, err_count, n_tests} = {16'h0044, 3'h1, 2'h0, 64'h0};
    for (int s = 0; s < 16; s++) begin
      start(s[3:0]);
      rd(vlmc_pkg::REG_STATUS);
      chk({29'h0, rdv[2:0]}, {29'h0, cfg});
      chk({30'h0, rdv[6], o_video_active}, {30'h0, {2{cfg > 3'h2}}});
      for (int m = 3; m >= 0; m--) begin
        wr(vlmc_pkg::REG_CTRL, 32'(m));
        rf = !(m == 0 || (m < 3 && cfg > 3'h2));
        if (!rf) mode = m[1:0];
        lanes(8);
        rd(vlmc_pkg::REG_STATUS);
        chk({30'h0, rdv[5:4]}, {30'h0, mode});
        chk({31'h0, o_pipe1_free}, {31'h0, mode != vlmc_pkg::MODE_DUAL_INDEP});
        rd(vlmc_pkg::REG_INT_STAT);
        chk({28'h0, rdv[3:0]}, {28'h0, rf, 3'h0});
        wr(vlmc_pkg::REG_INT_STAT, 32'h8);
      end
    end
    start(4'hC);
    wr(vlmc_pkg::REG_INT_MASK, 32'h5);
    rd(vlmc_pkg::REG_INT_MASK);
    chk(rdv, 32'h5);
    @(posedge i_mclk);
    evt <= 3'h7;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({31'h0, o_irq}, 32'h1);
    rd(vlmc_pkg::REG_INT_STAT);
    chk(rdv, 32'h7);
    wr(vlmc_pkg::REG_INT_STAT, 32'h5);
    @(negedge i_mclk);
    chk({31'h0, o_irq}, 32'h0);
    wr(vlmc_pkg::REG_INT_MASK, 32'h2);
    @(negedge i_mclk);
    chk({31'h0, o_irq}, 32'h1);
    wr(vlmc_pkg::REG_INT_STAT, 32'h2);
    rd(vlmc_pkg::REG_INT_STAT);
    chk({31'h0, o_irq}, 32'h0);
    chk(rdv, 32'h0);
    rd(8'h14);
    chk(rdv, 32'h0);
    e0 = tv_edges;
    @(posedge i_mclk);
    tv_run <= 1'b1;
    repeat (400) @(posedge i_mclk);
    tv_run <= 1'b0;
    repeat (60) @(posedge i_mclk);
    rd(vlmc_pkg::REG_TVCLK_CNT);
    chk({16'h0, rdv[15:0]}, {16'h0, 16'(tv_edges - e0)});
    stop_test;
  end
endmodule
